// [rtl/ccr_pkg.sv]
/*
  Constants, field layouts and carrier types shared by the charge current
  configuration register block and its current decoder.
  Assumes an 8-bit register address space reached through a byte-wide
  access port that is fed by the serial management front end.
*/
package ccr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MA_W   = 12;

  typedef logic [ADDR_W-1:0] ccr_addr_t;
  typedef logic [DATA_W-1:0] ccr_data_t;
  typedef logic [MA_W-1:0]   ccr_ma_t;

  // register indices in the bank
  localparam ccr_addr_t POWER_ON_CFG_ADDR = 8'h01;
  localparam ccr_addr_t FAST_CHG_ADDR     = 8'h02;
  localparam ccr_addr_t PRE_TERM_ADDR     = 8'h03;

  // register-reset control bit in the power-on configuration register
  localparam int REG_RESET_BIT = 7;

  // fast charge current register layout
  localparam int FAST_RSVD_BIT = 7;
  localparam int FAST_CODE_MSB = 6;
  localparam int FAST_CODE_LSB = 2;
  localparam int COLD_SEL_BIT  = 1;
  localparam int OVERRIDE_BIT  = 0;
  localparam int FAST_CODE_W   = FAST_CODE_MSB - FAST_CODE_LSB + 1;

  // pre-charge / termination register layout
  localparam int PRE_CODE_MSB  = 7;
  localparam int PRE_CODE_LSB  = 4;
  localparam int PT_RSVD_BIT   = 3;
  localparam int TERM_CODE_MSB = 2;
  localparam int TERM_CODE_LSB = 0;
  localparam int PRE_CODE_W    = PRE_CODE_MSB - PRE_CODE_LSB + 1;
  localparam int TERM_CODE_W   = TERM_CODE_MSB - TERM_CODE_LSB + 1;

  // reset values
  localparam logic [FAST_CODE_W-1:0] FAST_CODE_RST = 5'h18;
  localparam logic                   COLD_SEL_RST  = 1'b0;
  localparam logic                   OVERRIDE_RST  = 1'b0;
  localparam logic [PRE_CODE_W-1:0]  PRE_CODE_RST  = 4'h1;
  localparam logic [TERM_CODE_W-1:0] TERM_CODE_RST = 3'h1;
  localparam ccr_data_t              PRE_TERM_RST  = 8'h11;

  // decode figures in mA
  localparam ccr_ma_t FAST_BASE_MA = 12'h200;  // 512
  localparam ccr_ma_t FAST_STEP_MA = 12'h040;  // 64
  localparam ccr_ma_t FAST_MAX_MA  = 12'h800;  // 2048
  localparam ccr_ma_t PRE_STEP_MA  = 12'h080;  // 128
  localparam ccr_ma_t PRE_MIN_MA   = 12'h080;  // 128
  localparam logic [PRE_CODE_W-1:0] PRE_LINEAR_LAST = 4'h4;
  localparam ccr_ma_t TERM_BASE_MA = 12'h080;  // 128
  localparam ccr_ma_t TERM_STEP_MA = 12'h080;  // 128

  // reduced current override scaling
  localparam int FAST_PCT_NUM = 20;
  localparam int PCT_DEN      = 100;
  localparam int PRE_SHIFT    = 1;             // half

  typedef struct packed {
    logic [FAST_CODE_W-1:0] fast_charge_current_code;
    logic                   cold_threshold_high;
    logic                   reduced_current_override;
    logic [PRE_CODE_W-1:0]  precharge_current_code;
    logic [TERM_CODE_W-1:0] termination_current_code;
  } ccr_cfg_s;

  typedef struct packed {
    ccr_ma_t fast_charge_ma;
    ccr_ma_t precharge_current_setting;
    ccr_ma_t termination_ma;
  } ccr_setting_s;

endpackage : ccr_pkg

// [rtl/ccr_current_decode.sv]
/*
  Turns stored current codes into milliamp settings for the analogue loops,
  with the reduced-current override applied.
  Assumes its inputs come from flops on the same clock; output is registered
  in the parent.
*/
`timescale 1ns/1ps
module ccr_current_decode
  import ccr_pkg::*;
(
  input  wire ccr_cfg_s     cfg_i,
  output ccr_setting_s      setting_o
);

  function automatic ccr_ma_t fast_ma(input logic [FAST_CODE_W-1:0] code);
    fast_ma = FAST_BASE_MA + FAST_STEP_MA * ccr_ma_t'(code);
  endfunction

  function automatic ccr_ma_t pre_ma(input logic [PRE_CODE_W-1:0] code);
    if (code <= PRE_LINEAR_LAST) begin
      pre_ma = (code == '0) ? PRE_MIN_MA : PRE_STEP_MA * ccr_ma_t'(code);
    end else begin
      // above the last linear code the step skips one code's worth
      pre_ma = PRE_STEP_MA * (ccr_ma_t'(code) + ccr_ma_t'(1));
    end
  endfunction

  function automatic ccr_ma_t term_ma(input logic [TERM_CODE_W-1:0] code);
    term_ma = TERM_BASE_MA + TERM_STEP_MA * ccr_ma_t'(code);
  endfunction

  wire ccr_ma_t fast_prog;
  wire ccr_ma_t pre_prog;
  wire ccr_ma_t term_prog;
  wire ccr_ma_t fast_reduced;
  wire ccr_ma_t pre_reduced;
  wire [MA_W+7:0] fast_scaled;

  assign fast_prog = fast_ma(cfg_i.fast_charge_current_code);
  assign pre_prog  = pre_ma(cfg_i.precharge_current_code);
  assign term_prog = term_ma(cfg_i.termination_current_code);

  // integer scaling truncates toward zero, under a step of error
  assign fast_scaled  = ((MA_W+8)'(fast_prog) * (MA_W+8)'(FAST_PCT_NUM))
                        / (MA_W+8)'(PCT_DEN);
  assign fast_reduced = fast_scaled[MA_W-1:0];
  assign pre_reduced  = pre_prog >> PRE_SHIFT;

  assign setting_o.fast_charge_ma = cfg_i.reduced_current_override ?
                                    fast_reduced : fast_prog;
  assign setting_o.precharge_current_setting =
    cfg_i.reduced_current_override ? pre_reduced : pre_prog;
  assign setting_o.termination_ma = term_prog;

endmodule // ccr_current_decode

// [rtl/ccr_charge_current_regs.sv]
/*
  Fast charge and pre-charge/termination current configuration registers,
  with read-back and decoded settings for the charge control loops.
  Assumes a byte-wide access port driven on sys_clk_i by the serial
  management front end, one access per cycle at most.
*/
`timescale 1ns/1ps
// Summary of operation
// - The top bit of the fast charge register is reserved, held at zero, read as zero, and the host writes only zero there.
// - The fast charge code means 512 mA plus 1024, 512, 256, 128 and 64 mA weights from top to bottom bit.
// - After reset the fast charge code is the 2048 mA code, ones in its two top bits.
// - The cold select bit picks the low (zero, default) or high (one) boost cold threshold.
// - With the override bit set the loops get a fifth of the fast current and half of the pre-charge current.
// - Pre-charge codes 0 and 1 give 128 mA, codes 2 to 4 give 128 mA per step, and from code 5 at 768 mA each code adds 128 mA.
// - After reset the pre-charge code is 0001, 128 mA.
// - The termination code means 128 mA plus 512, 256 and 128 mA weights.
// - After reset the termination code is 001, 256 mA.
// - The pre-charge/termination register resets to 0x11 and its bit 3 is reserved at zero.
// - Writing one to the register-reset bit restores both registers to default, writing zero does nothing.
module ccr_charge_current_regs
  import ccr_pkg::*;
(
  input  wire logic      sys_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      wr_en_i,
  input  wire logic      rd_en_i,
  input  wire ccr_addr_t addr_i,
  input  wire ccr_data_t wdata_i,
  output ccr_data_t      rdata_o,
  output logic           rvalid_o,
  output logic           rhit_o,
  output logic           cold_threshold_high_o,
  output logic           reduced_current_override_o,
  output ccr_setting_s   setting_o,
  output logic           fast_code_unsupported_o
);

  ccr_cfg_s     cfg;
  ccr_cfg_s     next_cfg;
  ccr_setting_s setting;

  wire logic      wr_fast;
  wire logic      wr_pre_term;
  wire logic      reg_reset_cmd;
  wire logic      rd_fast;
  wire logic      rd_pre_term;
  wire ccr_data_t fast_view;
  wire ccr_data_t pre_term_view;
  wire ccr_data_t next_rdata;
  wire ccr_setting_s decoded;
  wire ccr_ma_t   fast_prog_ma;

  // access decode
  assign wr_fast       = wr_en_i && (addr_i == FAST_CHG_ADDR);
  assign wr_pre_term   = wr_en_i && (addr_i == PRE_TERM_ADDR);
  // the register-reset bit lives in the power-on register; only a write of
  // one there matters to this bank
  assign reg_reset_cmd = wr_en_i && (addr_i == POWER_ON_CFG_ADDR) &&
                         wdata_i[REG_RESET_BIT];
  assign rd_fast       = rd_en_i && (addr_i == FAST_CHG_ADDR);
  assign rd_pre_term   = rd_en_i && (addr_i == PRE_TERM_ADDR);

  // next state of the stored fields
  always_comb begin
    next_cfg = cfg;
    if (reg_reset_cmd) begin
      next_cfg.fast_charge_current_code = FAST_CODE_RST;
      next_cfg.cold_threshold_high      = COLD_SEL_RST;
      next_cfg.reduced_current_override = OVERRIDE_RST;
      next_cfg.precharge_current_code   = PRE_CODE_RST;
      next_cfg.termination_current_code = TERM_CODE_RST;
    end else begin
      if (wr_fast) begin
        // the reserved top bit is dropped, not stored
        next_cfg.fast_charge_current_code =
          wdata_i[FAST_CODE_MSB:FAST_CODE_LSB];
        next_cfg.cold_threshold_high      = wdata_i[COLD_SEL_BIT];
        next_cfg.reduced_current_override = wdata_i[OVERRIDE_BIT];
      end
      if (wr_pre_term) begin
        next_cfg.precharge_current_code =
          wdata_i[PRE_CODE_MSB:PRE_CODE_LSB];
        next_cfg.termination_current_code =
          wdata_i[TERM_CODE_MSB:TERM_CODE_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.fast_charge_current_code <= FAST_CODE_RST;
      cfg.cold_threshold_high      <= COLD_SEL_RST;
      cfg.reduced_current_override <= OVERRIDE_RST;
      cfg.precharge_current_code   <= PRE_CODE_RST;
      cfg.termination_current_code <= TERM_CODE_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // register images; reserved positions are constant zero
  assign fast_view = {1'b0,
                      cfg.fast_charge_current_code,
                      cfg.cold_threshold_high,
                      cfg.reduced_current_override};
  assign pre_term_view = {cfg.precharge_current_code,
                          1'b0,
                          cfg.termination_current_code};

  assign next_rdata = rd_fast     ? fast_view :
                      rd_pre_term ? pre_term_view : '0;

  // read data comes one cycle after the request; unmapped reads give zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
      rhit_o   <= 1'b0;
    end else begin
      rdata_o  <= next_rdata;
      rvalid_o <= rd_en_i;
      rhit_o   <= rd_fast || rd_pre_term;
    end
  end

  ccr_current_decode u_decode (
    .cfg_i     (cfg),
    .setting_o (decoded)
  );

  // unscaled fast current, for flagging unsupported codes
  assign fast_prog_ma = FAST_BASE_MA +
                        FAST_STEP_MA * ccr_ma_t'(cfg.fast_charge_current_code);

  // settings are registered so the analogue side sees no decode glitches
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setting.fast_charge_ma            <= FAST_MAX_MA;
      setting.precharge_current_setting <= PRE_MIN_MA;
      setting.termination_ma            <= TERM_BASE_MA + TERM_STEP_MA;
      cold_threshold_high_o             <= COLD_SEL_RST;
      reduced_current_override_o        <= OVERRIDE_RST;
      fast_code_unsupported_o           <= 1'b0;
    end else begin
      setting                    <= decoded;
      cold_threshold_high_o      <= cfg.cold_threshold_high;
      reduced_current_override_o <= cfg.reduced_current_override;
      // codes past 2048 mA are stored as written but flagged
      fast_code_unsupported_o    <= (fast_prog_ma > FAST_MAX_MA);
    end
  end

  assign setting_o = setting;

endmodule // ccr_charge_current_regs

// [testbench/ccr_regs_monitor.sv]
/*
  Port checker for the charge current configuration registers.
  Assumes one clock domain and is bound from the testbench top.
*/
`timescale 1ns/1ps
module ccr_regs_monitor
  import ccr_pkg::*;
(
  input wire logic         sys_clk_i,
  input wire logic         rst_n_i,
  input wire logic         wr_en_i,
  input wire logic         rd_en_i,
  input wire ccr_addr_t    addr_i,
  input wire ccr_data_t    wdata_i,
  input wire ccr_data_t    rdata_o,
  input wire logic         rvalid_o,
  input wire logic         rhit_o,
  input wire logic         cold_threshold_high_o,
  input wire logic         reduced_current_override_o,
  input wire ccr_setting_s setting_o,
  input wire logic         fast_code_unsupported_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // write data two edges back lines up with the settled decoded outputs
  ccr_data_t wd_q;
  ccr_data_t wd_qq;
  wire fast_wr = wr_en_i && addr_i == FAST_CHG_ADDR;
  wire fast_rd = rd_en_i && addr_i == FAST_CHG_ADDR;
  wire pt_rd   = rd_en_i && addr_i == PRE_TERM_ADDR;
  wire bank_rst = wr_en_i && addr_i == POWER_ON_CFG_ADDR &&
                  wdata_i[REG_RESET_BIT];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_q  <= 8'h00;
      wd_qq <= 8'h00;
    end else begin
      wd_q  <= wdata_i;
      wd_qq <= wd_q;
    end
  end
  read_answer_a: assert property (
    rd_en_i |=> rvalid_o && rhit_o == $past(fast_rd || pt_rd))
    else $error("read strobe not answered");
  fast_rsvd_a: assert property (
    fast_rd |=> !rdata_o[FAST_RSVD_BIT]) else $error("fast reserved bit set");
  pt_rsvd_a: assert property (
    pt_rd |=> !rdata_o[PT_RSVD_BIT]) else $error("pre reserved bit set");
  bank_reset_a: assert property (
    bank_rst ##1 (fast_rd && !wr_en_i) |=> rdata_o == 8'h60)
    else $error("register reset not applied");
  fast_decode_a: assert property (
    fast_wr && !wdata_i[0] |=> ##1 setting_o.fast_charge_ma ==
    FAST_BASE_MA + {1'b0, wd_qq[6:2], 6'h00}) else $error("fast decode");
  cold_sel_a: assert property (
    fast_wr |=> ##1 cold_threshold_high_o == wd_qq[1]) else $error("cold sel");
  override_a: assert property (
    fast_wr |=> ##1 reduced_current_override_o == wd_qq[0])
    else $error("override level");
  unsupported_a: assert property (
    fast_wr |=> ##1 fast_code_unsupported_o == (wd_qq[6:2] > 5'h18))
    else $error("unsupported flag");
endmodule // ccr_regs_monitor

// [testbench/charge_current_config_regs_test.sv]
/*
  Self-checking bench for the charge current configuration registers.
  Assumes the byte access port contract: one-cycle strobes, read data
  one cycle after the read strobe.
*/
`timescale 1ns/1ps
module charge_current_config_regs_test import ccr_pkg::*;;
  logic sys_clk_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0;
  ccr_addr_t    addr_i = 8'h00;
  ccr_data_t    wdata_i = 8'h00;
  ccr_data_t    rdata_o;
  logic         rvalid_o, rhit_o, cold_o, ovr_o, unsup_o;
  ccr_setting_s setting_o;
  int           n_mismatch = 0, samples_checked = 0, seed = 85;
  ccr_data_t    f, p;
  always #50 sys_clk_i = ~sys_clk_i;
  ccr_charge_current_regs dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .rhit_o(rhit_o), .cold_threshold_high_o(cold_o),
    .reduced_current_override_o(ovr_o), .setting_o(setting_o),
    .fast_code_unsupported_o(unsup_o));
  function automatic ccr_ma_t pre_ma(logic [3:0] c, logic o);
    ccr_ma_t m;
    m = c < 2 ? 12'h080 : c < 5 ? {1'b0, c, 7'h00} : {1'b0, c, 7'h00} + 12'h080;
    return o ? m >> 1 : m;
  endfunction
  function automatic ccr_setting_s exp_set(ccr_data_t fb, ccr_data_t pb);
    ccr_ma_t fm;
    fm = 12'h200 + {1'b0, fb[6:2], 6'h00};
    if (fb[0]) fm = 12'(fm * 20 / 100);  // truncating fifth
    return '{fm, pre_ma(pb[7:4], fb[0]), 12'h080 + {2'h0, pb[2:0], 7'h00}};
  endfunction
  task automatic chk(input logic [39:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic acc(input logic w, r, ccr_addr_t a, ccr_data_t d);
    @(posedge sys_clk_i);
    wr_en_i <= w;
    rd_en_i <= r;
    addr_i  <= a;
    wdata_i <= d;
  endtask
  task automatic rd(input ccr_addr_t a, ccr_data_t e);
    acc(0, 1, a, 8'h00);
    acc(0, 0, a, 8'h00);
    #1 chk({rvalid_o, rhit_o, rdata_o}, {1'b1, a inside {8'h02, 8'h03}, e}, "rd");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1;
    rd(8'h02, 8'h60);
    rd(8'h03, 8'h11);
    chk({unsup_o, setting_o}, {1'b0, 36'h800080100}, "dflt");
    $display("test defaults done");
    for (int i = 0; i < 40; i++) begin
      f = 8'($random(seed));
      p = 8'($random(seed));
      f[FAST_RSVD_BIT] = 1'b0;
      // random codes stay in the supported range; corners below misuse it
      if (f[6:2] > 5'h18) f[6:2] = 5'h18;
      // sweep every pre-charge code and fast code corners, incl. 0x18/0x1f
      if (i < 16) begin
        p[7:4] = i[3:0];
        f[6:2] = {i[3:0], i[0]};
      end
      acc(1, 0, 8'h02, f);
      acc(1, 0, 8'h03, p);
      rd(8'h02, f & 8'h7f);
      rd(8'h03, p & 8'hf7);
      chk(setting_o, exp_set(f, p), "decode");
      chk({cold_o, ovr_o, unsup_o}, {f[1], f[0], f[6:2] > 5'h18}, "flg");
    end
    $display("test random decode done");
    acc(1, 0, 8'h01, 8'h7f);
    rd(8'h02, f & 8'h7f);
    acc(1, 0, 8'h01, 8'h80);
    rd(8'h02, 8'h60);
    rd(8'h03, 8'h11);
    $display("test register reset done");
    acc(1, 0, 8'h05, 8'hff);
    rd(8'h05, 8'h00);
    acc(1, 1, 8'h02, 8'h04);
    acc(0, 0, 8'h00, 8'h00);
    #1 chk(rdata_o, 8'h60, "old on rw");
    rd(8'h02, 8'h04);
    $display("test unmapped and overlap done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule // charge_current_config_regs_test

bind ccr_charge_current_regs ccr_regs_monitor mon (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .rhit_o(rhit_o), .cold_threshold_high_o(cold_threshold_high_o),
  .reduced_current_override_o(reduced_current_override_o),
  .setting_o(setting_o), .fast_code_unsupported_o(fast_code_unsupported_o));
